// file: verification/fpp_flash_model.sv
// flash array engine model standing behind the programmer-side sequencer
`timescale 1ns/1ps
`default_nettype none
module fpp_flash_model (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// bench controls
	input  wire logic [8:0]  done_at,
	input  wire logic        fail_en,
	// array side
	input  wire logic [14:0] arr_addr,
	output logic [7:0]       arr_rd_data,
	input  wire logic        arr_prog_req,
	input  wire logic        arr_erase_req,
	input  wire logic [7:0]  arr_page,
	output logic [6:0]       arr_buf_idx,
	input  wire logic [7:0]  arr_buf_data,
	output logic             arr_done,
	output logic             arr_fail
);
	logic [8:0] cnt_q;
	logic       fin_q;
	logic [7:0] got [128];
	logic [7:0] got_page;

	// ==========================================================
	// contents
	// a fixed address pattern, so no backing store is needed
	assign arr_rd_data = arr_addr[7:0] ^ {1'b0, arr_addr[14:8]};
	assign arr_buf_idx = cnt_q[6:0];
	assign arr_fail    = arr_done & fail_en;

	// ==========================================================
	// run engine
	// done only once per request; a run may take as long as the bench asks
	always_ff @(posedge sys_clk) begin
		arr_done <= 1'b0;
		if (srst || !(arr_prog_req || arr_erase_req)) begin
			cnt_q <= 9'h000;
			fin_q <= 1'b0;
		end else if (!fin_q) begin
			if (arr_prog_req && !cnt_q[7])
				got[cnt_q[6:0]] <= arr_buf_data;
			cnt_q <= cnt_q + 9'h001;
			if (cnt_q == done_at) begin
				arr_done <= 1'b1;
				fin_q    <= 1'b1;
				got_page <= arr_page;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/fpp_top_tb.sv
// self-checking bench for the flash protection and programmer command block
`timescale 1ns/1ps
`default_nettype none
module fpp_top_tb;
	import fpp_pkg::*;
	logic sys_clk, srst, ce, ctl_wr, ebr_wr, hw_protect, boot_running;
	logic flash_area_read, exception_start, sleep_exec, flash_error_flag;
	logic program_pulse, erase_pulse, program_verify_mode, erase_verify_mode, irq_mask;
	logic prog_mode, flash_write_permit_pin, pgm_we, pgm_re, pgm_busy;
	logic arr_prog_req, arr_erase_req, arr_done, arr_fail, fail_en;
	fpp_ctl_t    ctl_wdata, flash_control_one;
	logic [7:0]  ebr_wdata, erase_block_select, erase_blocks, pgm_din, pgm_dout;
	logic [7:0]  arr_rd_data, arr_buf_data, arr_page, v;
	logic [16:0] pgm_addr;
	logic [14:0] arr_addr;
	logic [6:0]  arr_buf_idx;
	logic [8:0]  done_at;
	int          fail_count, tests_run;

	fpp_top i_fpp_top (.sys_clk, .srst, .ce, .ctl_wr, .ctl_wdata, .ebr_wr, .ebr_wdata, .hw_protect,
		.boot_running, .flash_area_read, .exception_start, .sleep_exec, .flash_control_one,
		.flash_error_flag, .erase_block_select, .program_pulse, .erase_pulse, .program_verify_mode,
		.erase_verify_mode, .erase_blocks, .irq_mask, .prog_mode, .flash_write_permit_pin, .pgm_we,
		.pgm_re, .pgm_addr, .pgm_din, .pgm_dout, .pgm_busy, .arr_addr, .arr_rd_data, .arr_prog_req,
		.arr_erase_req, .arr_page, .arr_buf_idx, .arr_buf_data, .arr_done, .arr_fail);

	fpp_flash_model i_fpp_flash_model (.sys_clk, .srst, .done_at, .fail_en, .arr_addr, .arr_rd_data,
		.arr_prog_req, .arr_erase_req, .arr_page, .arr_buf_idx, .arr_buf_data, .arr_done, .arr_fail);

	initial begin
		sys_clk = 1'b0;
		// fixed rate, never stopped while in programmer mode
		forever #10 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// access tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
	endtask

	task automatic ctlw(input logic [4:0] val);
		@(posedge sys_clk);
		ctl_wr    <= 1'b1;
		ctl_wdata <= val;
		@(posedge sys_clk);
		ctl_wr    <= 1'b0;
		#1;
	endtask

	task automatic ebrw(input logic [7:0] val);
		@(posedge sys_clk);
		ebr_wr    <= 1'b1;
		ebr_wdata <= val;
		@(posedge sys_clk);
		ebr_wr    <= 1'b0;
		#1;
	endtask

	// one-cycle event: 0 area read, 1 exception, 2 sleep, 3 mode transition
	task automatic ev(input int k);
		@(posedge sys_clk);
		case (k)
			0: flash_area_read <= 1'b1;
			1: exception_start <= 1'b1;
			2: sleep_exec      <= 1'b1;
			default: hw_protect <= 1'b1;
		endcase
		@(posedge sys_clk);
		{flash_area_read, exception_start, sleep_exec, hw_protect} <= 4'h0;
		#1;
	endtask

	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		pgm_we   <= 1'b1;
		pgm_addr <= a;
		pgm_din  <= d;
		@(posedge sys_clk);
		pgm_we   <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [16:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		pgm_re   <= 1'b1;
		pgm_addr <= a;
		@(posedge sys_clk);
		pgm_re   <= 1'b0;
		#1;
		d = pgm_dout;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 400; i++) begin
			if (pgm_busy === 1'b0)
				return;
			@(posedge sys_clk);
			#1;
		end
		fail_count++;
		$display("unexpected timeout: expected idle, seen busy");
		results();
	endtask

	// ==========================================================
	// scenarios
	initial begin
		// reset asserted from time zero so no edge sees unreset state
		{srst, ctl_wr, ebr_wr, hw_protect, boot_running, pgm_we, pgm_re, fail_en} = 8'h80;
		{flash_area_read, exception_start, sleep_exec} = 3'h0;
		ce = 1'b1;
		prog_mode = 1'b1;
		flash_write_permit_pin = 1'b1;
		ctl_wdata = 5'h00;
		ebr_wdata = 8'h00;
		pgm_addr = 17'h0_0000;
		pgm_din = 8'h00;
		done_at = 9'h005;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		#1;
		chk("control one", {3'h0, flash_control_one}, 8'h00);
		chk("error flag", {7'h00, flash_error_flag}, 8'h00);
		chk("read data", pgm_dout, 8'hFF);
		// program bit ignored until write enable is already stored
		ctlw(5'h01);
		chk("program pulse", {7'h00, program_pulse}, 8'h00);
		ctlw(5'h10);
		// enable low must freeze the control register
		@(posedge sys_clk);
		ce <= 1'b0;
		ctlw(5'h11);
		chk("program pulse", {7'h00, program_pulse}, 8'h00);
		@(posedge sys_clk);
		ce <= 1'b1;
		ctlw(5'h11);
		chk("program pulse", {7'h00, program_pulse}, 8'h01);
		chk("irq mask", {7'h00, irq_mask}, 8'h01);
		ctlw(5'h10);
		chk("program pulse", {7'h00, program_pulse}, 8'h00);
		chk("irq mask", {7'h00, irq_mask}, 8'h00);
		@(posedge sys_clk);
		boot_running <= 1'b1;
		#1;
		chk("irq mask", {7'h00, irq_mask}, 8'h01);
		@(posedge sys_clk);
		boot_running <= 1'b0;
		ctlw(5'h12);
		chk("erase pulse", {7'h00, erase_pulse}, 8'h01);
		chk("erase blocks", erase_blocks, 8'h00);
		ebrw(8'h04);
		chk("erase blocks", erase_blocks, 8'h04);
		ev(3);
		chk("control one", {3'h0, flash_control_one}, 8'h00);
		chk("block select", erase_block_select, 8'h00);
		chk("erase pulse", {7'h00, erase_pulse}, 8'h00);
		// each error cause, idle first and then during programming
		for (int k = 0; k < 3; k++) begin
			do_reset();
			ev(k);
			chk("error flag", {7'h00, flash_error_flag}, 8'h00);
			ctlw(5'h10);
			ctlw(5'h11);
			ev(k);
			chk("error flag", {7'h00, flash_error_flag}, 8'h01);
			chk("program pulse", {7'h00, program_pulse}, 8'h00);
			chk("control one", {3'h0, flash_control_one}, 8'h11);
			ctlw(5'h10);
			ctlw(5'h11);
			chk("control one", {3'h0, flash_control_one}, 8'h10);
			chk("program pulse", {7'h00, program_pulse}, 8'h00);
			ctlw(5'h1C);
			chk("verify modes", {6'h00, program_verify_mode, erase_verify_mode}, 8'h03);
			ev(3);
			chk("error flag", {7'h00, flash_error_flag}, 8'h01);
		end
		do_reset();
		// programmer: memory read inside and outside the flash window
		wr(17'h0_0000, FPP_CMD_READ);
		rd(17'h0_1234, v);
		chk("array read", v, 8'h26);
		rd(17'h0_7FFF, v);
		chk("array read", v, 8'h80);
		rd(17'h0_8000, v);
		chk("array read", v, 8'hFF);
		wr(17'h1_5555, FPP_CMD_ERS);
		wr(17'h0_0AAA, FPP_CMD_ERS);
		chk("busy", {7'h00, pgm_busy}, 8'h01);
		chk("erase request", {7'h00, arr_erase_req}, 8'h01);
		wait_idle();
		rd(17'h0_0010, v);
		chk("status after erase", v & 8'hBC, 8'h00);
		done_at = 9'h08C;
		for (int f = 0; f < 2; f++) begin
			fail_en = f[0];
			wr(17'h0_0000, FPP_CMD_PGM);
			for (int i = 0; i < 128; i++)
				wr(17'h0_0100 + 17'(i), 8'(i) ^ 8'h5A);
			chk("busy", {7'h00, pgm_busy}, 8'h01);
			wait_idle();
			chk("page", i_fpp_flash_model.got_page, 8'h02);
			for (int i = 0; i < 128; i++)
				chk("page byte", i_fpp_flash_model.got[i], 8'(i) ^ 8'h5A);
			wr(17'h0_0000, FPP_CMD_STS);
			wr(17'h0_0000, FPP_CMD_STS);
			rd(17'h0_0000, v);
			chk("status", v & 8'hBC, f[0] ? 8'h10 : 8'h00);
		end
		wr(17'h0_0000, 8'h55);
		chk("busy", {7'h00, pgm_busy}, 8'h00);
		rd(17'h0_1234, v);
		chk("bad command", v & 8'h08, 8'h08);
		wr(17'h0_0000, FPP_CMD_READ);
		rd(17'h0_1234, v);
		chk("array read", v, 8'h26);
		// leaving programmer mode drops read mode; permit low blocks erase
		@(posedge sys_clk);
		prog_mode              <= 1'b0;
		flash_write_permit_pin <= 1'b0;
		@(posedge sys_clk);
		prog_mode <= 1'b1;
		wr(17'h0_0000, FPP_CMD_ERS);
		wr(17'h0_0000, FPP_CMD_ERS);
		chk("erase request", {7'h00, arr_erase_req}, 8'h00);
		chk("busy", {7'h00, pgm_busy}, 8'h00);
		rd(17'h0_1234, v);
		chk("status after exit", v & 8'hBC, 8'h10);
		results();
	end
endmodule
`default_nettype wire

// file: verilog/fpp_err_latch.sv
// error protection latch, cleared by power-on reset only
`timescale 1ns/1ps
`default_nettype none
module fpp_err_latch (
	// clock and power-on reset
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic ce,
	// error causes
	input  wire logic active,
	input  wire logic area_read,
	input  wire logic exc_start,
	input  wire logic sleep_exec,
	// flag
	output logic      err_q
);
	import fpp_pkg::*;

	logic err_d;

	// ==========================================================
	// latch
	always_comb begin
		err_d = err_q;
		if (active && (area_read || exc_start || sleep_exec)) begin
			err_d = 1'b1;
		end
	end

	// srst is the power-on reset; nothing else clears the flag
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			err_q <= 1'b0;
		end else if (ce) begin
			err_q <= err_d;
		end
	end

	// ==========================================================
	// checks
	AST_ERR_HOLD: assert property (@(posedge sys_clk) disable iff (srst) err_q |=> err_q)
		else $error("error flag cleared without power-on reset");

endmodule
`default_nettype wire

// file: verilog/fpp_page_buf.sv
// 128-byte page latch for auto-program
`timescale 1ns/1ps
`default_nettype none
module fpp_page_buf (
	// clock
	input  wire logic                          sys_clk,
	input  wire logic                          srst,
	input  wire logic                          ce,
	// fill side
	input  wire logic                          wr_en,
	input  wire logic [fpp_pkg::FPP_IDX_W-1:0] wr_idx,
	input  wire logic [7:0]                    wr_data,
	// drain side
	input  wire logic [fpp_pkg::FPP_IDX_W-1:0] rd_idx,
	output logic [7:0]                         rd_data
);
	import fpp_pkg::*;

	logic [7:0] mem_q [0:(1<<FPP_IDX_W)-1];

	// ==========================================================
	// storage, blank after reset so bytes not written since reset read as erased
	genvar gi;
	generate
		for (gi = 0; gi < (1 << FPP_IDX_W); gi++) begin : g_byte
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					mem_q[gi] <= FPP_BLANK;
				end else if (ce && wr_en && (wr_idx == FPP_IDX_W'(gi))) begin
					mem_q[gi] <= wr_data;
				end
			end
		end
	endgenerate

	assign rd_data = mem_q[rd_idx];

endmodule
`default_nettype wire

// file: verilog/fpp_pkg.sv
// shared constants and types for the flash protection and programmer command block
package fpp_pkg;

	// ==========================================================
	// widths
	localparam int FPP_ADDR_W = 17;
	localparam int FPP_FA_W   = 15;
	localparam int FPP_EBR_W  = 8;
	localparam int FPP_IDX_W  = 7;
	localparam int FPP_PAGE_W = FPP_FA_W - FPP_IDX_W;

	// ==========================================================
	// programmer address space and page
	localparam logic [FPP_ADDR_W-1:0] FPP_FLASH_TOP  = 17'h0_7FFF;
	localparam logic [7:0]            FPP_PAGE_BYTES = 8'h80;
	localparam logic [7:0]            FPP_LAST_BYTE  = 8'h7F;
	localparam logic [7:0]            FPP_BLANK      = 8'hFF;

	// ==========================================================
	// programmer command bytes
	localparam logic [7:0] FPP_CMD_READ = 8'h00;
	localparam logic [7:0] FPP_CMD_PGM  = 8'h40;
	localparam logic [7:0] FPP_CMD_ERS  = 8'h20;
	localparam logic [7:0] FPP_CMD_STS  = 8'h71;

	// ==========================================================
	// status byte fields
	localparam int FPP_STS_BUSY  = 7;
	localparam int FPP_STS_ERS_F = 5;
	localparam int FPP_STS_PGM_F = 4;
	localparam int FPP_STS_CMD_E = 3;
	localparam int FPP_STS_RANGE = 2;

	// ==========================================================
	// reset values
	localparam logic [FPP_EBR_W-1:0] FPP_EBR_RST = 8'h00;
	localparam logic [7:0]           FPP_STS_RST = 8'h00;
	localparam logic [7:0]           FPP_CNT_RST = 8'h00;

	// ==========================================================
	// types
	typedef struct packed {
		logic software_write_enable;
		logic ev;
		logic pv;
		logic e;
		logic p;
	} fpp_ctl_t;

	localparam fpp_ctl_t FPP_CTL_RST = '{software_write_enable: 1'b0, ev: 1'b0, pv: 1'b0, e: 1'b0, p: 1'b0};

	typedef enum logic [2:0] {
		FPP_ST_WAIT    = 3'b000,
		FPP_ST_PGM_LD  = 3'b001,
		FPP_ST_PGM_RUN = 3'b011,
		FPP_ST_ERS_2ND = 3'b010,
		FPP_ST_ERS_RUN = 3'b110,
		FPP_ST_STS_2ND = 3'b111,
		FPP_ST_STS_OUT = 3'b101,
		FPP_ST_READ    = 3'b100
	} fpp_state_t;

endpackage

// file: verilog/fpp_top.sv
// flash program/erase protection and programmer-mode command sequencer
`timescale 1ns/1ps
`default_nettype none
module fpp_top (
	// clock, power-on reset, enable
	input  wire logic                           sys_clk,
	input  wire logic                           srst,
	input  wire logic                           ce,
	// cpu control writes
	input  wire logic                           ctl_wr,
	input  wire fpp_pkg::fpp_ctl_t              ctl_wdata,
	input  wire logic                           ebr_wr,
	input  wire logic [fpp_pkg::FPP_EBR_W-1:0]  ebr_wdata,
	// system events
	input  wire logic                           hw_protect,
	input  wire logic                           boot_running,
	input  wire logic                           flash_area_read,
	input  wire logic                           exception_start,
	input  wire logic                           sleep_exec,
	// cpu side state
	output fpp_pkg::fpp_ctl_t                   flash_control_one,
	output logic                                flash_error_flag,
	output logic [fpp_pkg::FPP_EBR_W-1:0]       erase_block_select,
	output logic                                program_pulse,
	output logic                                erase_pulse,
	output logic                                program_verify_mode,
	output logic                                erase_verify_mode,
	output logic [fpp_pkg::FPP_EBR_W-1:0]       erase_blocks,
	output logic                                irq_mask,
	// programmer port
	input  wire logic                           prog_mode,
	input  wire logic                           flash_write_permit_pin,
	input  wire logic                           pgm_we,
	input  wire logic                           pgm_re,
	input  wire logic [fpp_pkg::FPP_ADDR_W-1:0] pgm_addr,
	input  wire logic [7:0]                     pgm_din,
	output logic [7:0]                          pgm_dout,
	output logic                                pgm_busy,
	// flash array engine
	output logic [fpp_pkg::FPP_FA_W-1:0]        arr_addr,
	input  wire logic [7:0]                     arr_rd_data,
	output logic                                arr_prog_req,
	output logic                                arr_erase_req,
	output logic [fpp_pkg::FPP_PAGE_W-1:0]      arr_page,
	input  wire logic [fpp_pkg::FPP_IDX_W-1:0]  arr_buf_idx,
	output logic [7:0]                          arr_buf_data,
	input  wire logic                           arr_done,
	input  wire logic                           arr_fail
);
	import fpp_pkg::*;

	// ==========================================================
	// decode helpers
	function automatic logic fpp_in_range(input logic [FPP_ADDR_W-1:0] a);
		fpp_in_range = (a <= FPP_FLASH_TOP);
	endfunction

	function automatic fpp_state_t fpp_dispatch(input logic [7:0] b, input logic permit);
		case (b)
			FPP_CMD_READ: fpp_dispatch = FPP_ST_READ;
			FPP_CMD_PGM:  fpp_dispatch = permit ? FPP_ST_PGM_LD : FPP_ST_WAIT;
			FPP_CMD_ERS:  fpp_dispatch = permit ? FPP_ST_ERS_2ND : FPP_ST_WAIT;
			FPP_CMD_STS:  fpp_dispatch = FPP_ST_STS_2ND;
			default:      fpp_dispatch = FPP_ST_WAIT;
		endcase
	endfunction

	function automatic logic fpp_known(input logic [7:0] b);
		fpp_known = (b == FPP_CMD_READ) || (b == FPP_CMD_PGM) || (b == FPP_CMD_ERS) || (b == FPP_CMD_STS);
	endfunction

	// ==========================================================
	// cpu control registers
	fpp_ctl_t              ctl_q;
	fpp_ctl_t              ctl_d;
	logic [FPP_EBR_W-1:0]  ebr_q;
	logic [FPP_EBR_W-1:0]  ebr_d;
	logic                  err_q;
	logic                  set_ok;
	logic                  active;

	// setting p or e needs write enable already on and no error; clearing is always allowed
	assign set_ok = ctl_q.software_write_enable && !err_q;

	always_comb begin
		ctl_d = ctl_q;
		ebr_d = ebr_q;
		if (hw_protect) begin
			ctl_d = FPP_CTL_RST;
			ebr_d = FPP_EBR_RST;
		end else begin
			if (ctl_wr) begin
				ctl_d   = ctl_wdata;
				ctl_d.p = ctl_wdata.p && (ctl_q.p || set_ok);
				ctl_d.e = ctl_wdata.e && (ctl_q.e || set_ok);
			end
			if (ebr_wr) begin
				ebr_d = ebr_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctl_q <= FPP_CTL_RST;
			ebr_q <= FPP_EBR_RST;
		end else if (ce) begin
			ctl_q <= ctl_d;
			ebr_q <= ebr_d;
		end
	end

	// bits stay as written after an error, only the pulse is cut
	assign program_pulse       = ctl_q.software_write_enable && ctl_q.p && !err_q;
	assign erase_pulse         = ctl_q.software_write_enable && ctl_q.e && !err_q;
	assign program_verify_mode = ctl_q.software_write_enable && ctl_q.pv;
	assign erase_verify_mode   = ctl_q.software_write_enable && ctl_q.ev;
	assign erase_blocks        = erase_pulse ? ebr_q : FPP_EBR_RST;
	assign active              = program_pulse || erase_pulse;
	assign irq_mask            = active || boot_running;
	assign flash_control_one   = ctl_q;
	assign erase_block_select  = ebr_q;
	assign flash_error_flag    = err_q;

	fpp_err_latch i_fpp_err_latch (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.ce         (ce),
		.active     (active),
		.area_read  (flash_area_read),
		.exc_start  (exception_start),
		.sleep_exec (sleep_exec),
		.err_q      (err_q)
	);

	// ==========================================================
	// programmer command sequencer
	fpp_state_t            st_q;
	fpp_state_t            st_d;
	logic [7:0]            cnt_q;
	logic [7:0]            cnt_d;
	logic [FPP_PAGE_W-1:0] page_q;
	logic [FPP_PAGE_W-1:0] page_d;
	logic [7:0]            sts_q;
	logic [7:0]            sts_d;
	logic [7:0]            dout_q;
	logic [7:0]            dout_d;
	logic                  buf_wr;
	logic                  running;
	logic [7:0]            sts_view;

	assign running  = (st_q == FPP_ST_PGM_RUN) || (st_q == FPP_ST_ERS_RUN);
	assign sts_view = {running, sts_q[6:0]};
	assign buf_wr   = (st_q == FPP_ST_PGM_LD) && pgm_we;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		page_d = page_q;
		sts_d  = sts_q;
		dout_d = dout_q;
		if (!prog_mode) begin
			st_d = FPP_ST_WAIT;
		end else begin
			case (st_q)
				FPP_ST_WAIT, FPP_ST_READ, FPP_ST_STS_OUT: begin
					if (pgm_re) begin
						if (st_q == FPP_ST_READ) begin
							dout_d = fpp_in_range(pgm_addr) ? arr_rd_data : FPP_BLANK;
						end else begin
							dout_d = sts_view;
						end
						if (st_q == FPP_ST_STS_OUT) begin
							st_d = FPP_ST_WAIT;
						end
					end else if (pgm_we) begin
						st_d  = fpp_dispatch(pgm_din, flash_write_permit_pin);
						cnt_d = FPP_CNT_RST;
						sts_d[FPP_STS_CMD_E] = !fpp_known(pgm_din);
					end
				end
				FPP_ST_PGM_LD: begin
					if (pgm_we) begin
						if (cnt_q == FPP_CNT_RST) begin
							page_d = pgm_addr[FPP_FA_W-1:FPP_IDX_W];
							sts_d[FPP_STS_PGM_F] = 1'b0;
							sts_d[FPP_STS_RANGE] = 1'b0;
						end
						if (!fpp_in_range(pgm_addr)) begin
							sts_d[FPP_STS_RANGE] = 1'b1;
						end
						cnt_d = cnt_q + 8'h01;
						if (cnt_q == FPP_LAST_BYTE) begin
							st_d = FPP_ST_PGM_RUN;
						end
					end
				end
				FPP_ST_ERS_2ND: begin
					if (pgm_we) begin
						st_d = (pgm_din == FPP_CMD_ERS) ? FPP_ST_ERS_RUN : FPP_ST_WAIT;
						sts_d[FPP_STS_ERS_F] = 1'b0;
						sts_d[FPP_STS_CMD_E] = (pgm_din != FPP_CMD_ERS);
					end
				end
				FPP_ST_STS_2ND: begin
					if (pgm_we) begin
						st_d = (pgm_din == FPP_CMD_STS) ? FPP_ST_STS_OUT : FPP_ST_WAIT;
						sts_d[FPP_STS_CMD_E] = (pgm_din != FPP_CMD_STS);
					end
				end
				FPP_ST_PGM_RUN, FPP_ST_ERS_RUN: begin
					if (pgm_re) begin
						dout_d = sts_view;
					end
					if (arr_done) begin
						st_d = FPP_ST_WAIT;
						if (st_q == FPP_ST_PGM_RUN) begin
							sts_d[FPP_STS_PGM_F] = arr_fail;
						end else begin
							sts_d[FPP_STS_ERS_F] = arr_fail;
						end
					end
				end
				default: begin
					st_d = FPP_ST_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q   <= FPP_ST_WAIT;
			cnt_q  <= FPP_CNT_RST;
			page_q <= '0;
			sts_q  <= FPP_STS_RST;
			dout_q <= FPP_BLANK;
		end else if (ce) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			page_q <= page_d;
			sts_q  <= sts_d;
			dout_q <= dout_d;
		end
	end

	// page stays in the buffer and the engine fetches it one byte per cycle through arr_buf_idx
	assign arr_prog_req  = (st_q == FPP_ST_PGM_RUN);
	assign arr_erase_req = (st_q == FPP_ST_ERS_RUN);
	assign arr_page      = page_q;
	assign arr_addr      = pgm_addr[FPP_FA_W-1:0];
	assign pgm_dout      = dout_q;
	assign pgm_busy      = running;

	fpp_page_buf i_fpp_page_buf (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.wr_en   (buf_wr),
		.wr_idx  (pgm_addr[FPP_IDX_W-1:0]),
		.wr_data (pgm_din),
		.rd_idx  (arr_buf_idx),
		.rd_data (arr_buf_data)
	);

	// ==========================================================
	// checks
	AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (srst)
		(program_pulse || erase_pulse || boot_running) |-> irq_mask)
		else $error("interrupts not masked during flash operation");

	AST_HW_PROTECT: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && hw_protect) |=> (ctl_q == FPP_CTL_RST) && (ebr_q == FPP_EBR_RST) && !active)
		else $error("mode transition did not reinitialise control");

	AST_SWE_BLOCK: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && ctl_wr && !ctl_q.software_write_enable && !ctl_q.p && !ctl_q.e) |=> !program_pulse && !erase_pulse)
		else $error("program or erase entered without write enable");

	AST_ERASE_MASK: assert property (@(posedge sys_clk) disable iff (srst)
		(erase_blocks & ~ebr_q) == FPP_EBR_RST)
		else $error("unselected block erased");

	AST_ERR_READ: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && active && flash_area_read) |=> err_q && !program_pulse && !erase_pulse)
		else $error("flash read during operation not caught");

	AST_ERR_EXC: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && active && exception_start) |=> err_q)
		else $error("exception during operation not caught");

	AST_ERR_KEEP: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && active && sleep_exec && !ctl_wr && !hw_protect) |=> err_q && $stable(ctl_q) && !active)
		else $error("error did not keep settings and stop the pulse");

	AST_ERR_REFUSE: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && err_q && ctl_wr && !hw_protect && !ctl_q.p) |=> !ctl_q.p ##0 (ctl_q.pv == $past(ctl_wdata.pv)))
		else $error("error state accepted program bit or refused verify");

	AST_PGM_COUNT: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prog_mode && st_q == FPP_ST_PGM_LD && pgm_we && cnt_q == FPP_LAST_BYTE) |=> arr_prog_req)
		else $error("page not launched after last byte");

	AST_RETURN: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prog_mode && running && arr_done) |=> (st_q == FPP_ST_WAIT) && !pgm_busy)
		else $error("no return to command wait");

	AST_UNKNOWN: assert property (@(posedge sys_clk) disable iff (srst)
		(ce && prog_mode && st_q == FPP_ST_WAIT && !pgm_re && pgm_we && !fpp_known(pgm_din))
		|=> st_q == FPP_ST_WAIT)
		else $error("unknown command left command wait");

	COV_PGM: cover property (@(posedge sys_clk) disable iff (srst) arr_prog_req ##1 arr_done);
	COV_ERS: cover property (@(posedge sys_clk) disable iff (srst) st_q == FPP_ST_ERS_RUN);
	COV_STS: cover property (@(posedge sys_clk) disable iff (srst) st_q == FPP_ST_STS_OUT ##1 st_q == FPP_ST_WAIT);
	COV_ERR: cover property (@(posedge sys_clk) disable iff (srst) active ##1 err_q);

endmodule
`default_nettype wire
